// File: shared/ubg_pkg.sv
// Package of constants and types for the break and idle generator
package ubg_pkg;
  localparam int unsigned BRK_BITS_SHORT = 10;
  localparam int unsigned BRK_BITS_LONG = 11;
  localparam int unsigned IDLE_BITS_SHORT = 10;
  localparam int unsigned IDLE_BITS_LONG = 11;
  localparam int unsigned BAUD_DIV_DEF = 16'h0015;
  localparam int unsigned DIV_W = 16;
  localparam int unsigned BITCNT_W = 4;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic LINE_BREAK = 1'b0;

  typedef enum logic [1:0] {
    UBG_FS_IDLE = 2'b00,
    UBG_FS_PRE = 2'b01,
    UBG_FS_BRK = 2'b10
  } ubg_state_t;

  // Frame length in bit periods for the character-length select
  function automatic logic [3:0] ubg_frame_bits(input logic long_sel, input logic is_brk);
    if (is_brk) begin
      ubg_frame_bits = long_sel ? 4'(BRK_BITS_LONG) : 4'(BRK_BITS_SHORT);
    end else begin
      ubg_frame_bits = long_sel ? 4'(IDLE_BITS_LONG) : 4'(IDLE_BITS_SHORT);
    end
  endfunction : ubg_frame_bits
endpackage : ubg_pkg

// File: shared/ubg_tick_if.sv
// Interface carrying the bit-period tick between the divider and the generator
`timescale 1ns/1ps
interface ubg_tick_if;
  logic restart;
  logic tick;
  modport src (input restart, output tick);
  modport dst (output restart, input tick);
endinterface : ubg_tick_if

// File: rtl/ubg_baud_div.sv
// Bit-period divider producing a one-cycle tick
`timescale 1ns/1ps
module ubg_baud_div
  import ubg_pkg::*;
#(
  parameter int unsigned DIV_W_P = DIV_W
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [DIV_W_P-1:0] div_i,
  ubg_tick_if.src tk
);
  logic [DIV_W_P-1:0] cnt_ff;
  logic [DIV_W_P-1:0] nxt_cnt;
  wire logic at_end = (cnt_ff >= div_i - DIV_W_P'(1)) || (div_i == '0);

  // Restart aligns the first bit period with the frame start
  assign nxt_cnt = (tk.restart || at_end) ? '0 : cnt_ff + DIV_W_P'(1);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tk.tick = at_end && !tk.restart;
endmodule : ubg_baud_div

// File: rtl/ubg_break_idle_gen.sv
// Break and idle-line generator for an asynchronous transmitter
// Overview of operation
// [RULE1] Setting then clearing send_break_bit sends exactly one break character; the code sends none for a set cleared within an active break.
// [RULE2] A break lasts 10 bit periods with char_len_sel_i low and 11 with it high.
// [RULE3] While send_break_bit stays set, breaks are sent back to back.
// [RULE4] A low-then-high of transmitter_enable_bit queues one idle character first; the code sends a break first for a set in the cycle enable rises.
// [RULE5] An idle queued ahead of a break is sent immediately before that break.
// [RULE6] A break after an idle always has its nominal length, never extended.
// [RULE7] Software issues nothing between the idle request and the break request.
// [RULE8] A break holds the line low for its length; an idle holds it high one frame.
`timescale 1ns/1ps
module ubg_break_idle_gen
  import ubg_pkg::*;
#(
  parameter int unsigned BAUD_DIV = BAUD_DIV_DEF
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic send_break_bit_i,
  input wire logic transmitter_enable_bit_i,
  input wire logic char_len_sel_i,
  output logic tx_o,
  output logic busy_o,
  output logic break_active_o,
  output logic idle_active_o
);
  ////////////////////////////////////////////////////////////////////////////
  ubg_tick_if tk_if ();
  ubg_state_t state_ff;
  ubg_state_t nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic en_d_ff;
  logic idle_pend_ff;
  logic brk_seen_ff;
  logic tx_ff;
  logic busy_ff;
  logic brk_act_ff;
  logic idle_act_ff;

  ubg_baud_div #(.DIV_W_P(DIV_W)) u_div (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .div_i(DIV_W'(BAUD_DIV)),
    .tk(tk_if.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  wire logic en_rise = transmitter_enable_bit_i && !en_d_ff; // RULE4
  wire logic frame_last = tk_if.tick && (bit_cnt_ff == 4'h1);
  // A break request is the bit itself or a set pulse already caught
  wire logic brk_req = send_break_bit_i || brk_seen_ff; // RULE1
  wire logic idle_start = (state_ff == UBG_FS_IDLE) && idle_pend_ff; // RULE5
  wire logic brk_start = (state_ff == UBG_FS_IDLE) && !idle_pend_ff && brk_req;
  wire logic pre_to_brk = (state_ff == UBG_FS_PRE) && frame_last && brk_req; // RULE5
  wire logic brk_again = (state_ff == UBG_FS_BRK) && frame_last && send_break_bit_i; // RULE3
  // Frame length is latched at start so a late select change cannot stretch it
  wire logic load_brk = brk_start || pre_to_brk || brk_again; // RULE6
  assign tk_if.restart = idle_start || brk_start;

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    if (idle_start) begin
      nxt_state = UBG_FS_PRE;
      nxt_bit_cnt = ubg_frame_bits(char_len_sel_i, 1'b0); // RULE8
    end else if (load_brk) begin
      nxt_state = UBG_FS_BRK;
      nxt_bit_cnt = ubg_frame_bits(char_len_sel_i, 1'b1); // RULE2
    end else if (tk_if.tick && (state_ff != UBG_FS_IDLE)) begin
      nxt_bit_cnt = bit_cnt_ff - 4'h1;
      if (bit_cnt_ff == 4'h1) begin
        nxt_state = UBG_FS_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_ff <= UBG_FS_IDLE;
      bit_cnt_ff <= 4'h0;
      en_d_ff <= 1'b0;
      idle_pend_ff <= 1'b0;
      brk_seen_ff <= 1'b0;
      tx_ff <= LINE_IDLE;
      busy_ff <= 1'b0;
      brk_act_ff <= 1'b0;
      idle_act_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      en_d_ff <= transmitter_enable_bit_i;
      // A new toggle wins over the consume of an older one
      idle_pend_ff <= en_rise || (idle_pend_ff && !idle_start); // RULE4
      // Keeps a set that does not start a break at once, unless a break is already active, even one that meets an idle start
      brk_seen_ff <= (send_break_bit_i && !load_brk && !brk_act_ff)
        || (brk_seen_ff && !load_brk); // RULE1
      tx_ff <= (nxt_state == UBG_FS_BRK) ? LINE_BREAK : LINE_IDLE; // RULE8
      busy_ff <= (nxt_state != UBG_FS_IDLE);
      brk_act_ff <= (nxt_state == UBG_FS_BRK);
      idle_act_ff <= (nxt_state == UBG_FS_PRE);
    end
  end

  assign tx_o = tx_ff;
  assign busy_o = busy_ff;
  assign break_active_o = brk_act_ff;
  assign idle_active_o = idle_act_ff;
endmodule : ubg_break_idle_gen

// File: bench/ubg_chk.sv
// Checker
`timescale 1ns/1ps
module ubg_chk (
  input wire logic clk_i, rstn_i, send_break_bit_i, transmitter_enable_bit_i,
  input wire logic tx_o, busy_o, break_active_o, idle_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_line_level: assert property (tx_o == !break_active_o) else $error("line");
  a_busy_kind: assert property (busy_o == (break_active_o ^ idle_active_o))
    else $error("busy");
  a_idle_first: assert property ($rose(transmitter_enable_bit_i) && !busy_o
    && !send_break_bit_i |-> ##2 idle_active_o) else $error("idle");
  a_brk_start: assert property ($past(rstn_i, 2) && $past(rstn_i) && send_break_bit_i
    && !busy_o && !$past(busy_o) && $stable(transmitter_enable_bit_i)
    && $past(transmitter_enable_bit_i) == $past(transmitter_enable_bit_i, 2)
    |=> break_active_o) else $error("brk");
  a_idle_high: assert property (idle_active_o |-> tx_o) else $error("idle low");
  a_brk_chain: assert property (break_active_o && send_break_bit_i
    && $past(send_break_bit_i) |=> busy_o) else $error("gap");
  c_a: cover property ($rose(break_active_o));
  c_b: cover property (break_active_o && send_break_bit_i);
  c_c: cover property (idle_active_o ##1 break_active_o);
endmodule : ubg_chk
bind ubg_break_idle_gen ubg_chk u_chk (.*);

// File: bench/ubg_rx_model.sv
// Far-end receiver
`timescale 1ns/1ps
module ubg_rx_model (input wire logic clk_i, rx_i, output int low_len_o);
  logic prev = 1'b1;
  int run = 0;
  always @(posedge clk_i) begin
    prev <= rx_i;
    run <= (rx_i == prev) ? run + 1 : 1;
    if (rx_i && !prev) low_len_o <= run;
  end
endmodule : ubg_rx_model

// File: bench/uart_break_idle_generator_bench.sv
// Bench
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] %0t bad", $time); end end
module uart_break_idle_generator_bench;
  localparam int B = 2;
  logic clk_i = 0, rstn_i = 0, brk_set = 0, tx_en = 1, sel = 0, tx, busy, brk, idl;
  int n_mismatch = 0, num_checks = 0, low_len, i;
  int rows[4][4] = '{'{0, 1, 0, 10}, '{1, 1, 0, 11}, '{0, 23, 0, 20}, '{1, 1, 1, 11}};
  always #12.5 clk_i = ~clk_i;
  ubg_break_idle_gen #(.BAUD_DIV(B)) dut (.clk_i, .rstn_i, .send_break_bit_i(brk_set),
    .transmitter_enable_bit_i(tx_en), .char_len_sel_i(sel), .tx_o(tx), .busy_o(busy),
    .break_active_o(brk), .idle_active_o(idl));
  ubg_rx_model rx (.clk_i, .rx_i(tx), .low_len_o(low_len));
  task automatic tally_and_finish();
    $display("checks %0d errs %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wait_free();
    repeat (500) if (busy !== 1'b0) @(negedge clk_i);
    `CHK(busy, 1'b0)
    if (busy !== 1'b0) tally_and_finish();
  endtask : wait_free
  // Enable is high at release, so each reset is followed by one idle frame
  task automatic release_reset();
    rstn_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    `CHK(idl, 1'b1)
    wait_free();
  endtask : release_reset
  initial begin
    repeat (8) @(posedge clk_i);
    release_reset();
    for (i = 0; i < 4; i++) begin
      @(posedge clk_i) tx_en <= !rows[i][2][0];
      @(posedge clk_i) tx_en <= 1'b1;
      @(posedge clk_i) brk_set <= 1'b1;
      sel <= rows[i][0][0];
      repeat (rows[i][1]) @(posedge clk_i);
      brk_set <= 1'b0;
      @(negedge clk_i) `CHK(idl, rows[i][2][0])
      wait_free();
      repeat (2) @(negedge clk_i);
      `CHK(low_len, rows[i][3] * B)
    end
    // Reset in mid-break must drop the line back to idle at the next clock edge
    @(posedge clk_i) brk_set <= 1'b1;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b0;
    @(negedge clk_i) `CHK(brk, 1'b1)
    `CHK(tx, 1'b0)
    @(posedge clk_i) brk_set <= 1'b0;
    @(negedge clk_i) `CHK(tx, 1'b1)
    `CHK(busy, 1'b0)
    repeat (2) @(posedge clk_i);
    release_reset();
    tally_and_finish();
  end
endmodule : uart_break_idle_generator_bench
